// ==== test/term_monitor.sv ====
`timescale 1ns/100ps
module term_monitor (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic select_n,
   input wire logic data_strobe_n,
   input wire logic rd_wr,
   input wire logic host_ready_n,
   input wire logic data_host_oe,
   input wire logic data_dev_oe,
   input wire logic interrupt_n,
   input wire logic memory_write_pulse_n,
   input wire logic ram_enable_out_n,
   input wire logic internal_ram_enable_in_n,
   input wire logic master_clear_n,
   input wire logic address_match_pulse_n,
   input wire logic tx_rx_bit,
   input wire logic mode_code_flag,
   input wire logic in_message
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // host has let go of select long enough for the sync flops
   sequence released_s;
      select_n [*6];
   endsequence
   // master clear held through its two sync flops
   sequence clear_held_s;
      !master_clear_n [*3];
   endsequence
   chk_match_pulse_width:
      assert property ($fell(address_match_pulse_n) |=> address_match_pulse_n)
      else $error("address match pulse longer than one cycle");
   chk_irq_pulse_width:
      assert property ($fell(interrupt_n) |=> interrupt_n)
      else $error("interrupt held as a level");
   chk_write_pulse_width:
      assert property ($fell(memory_write_pulse_n) |=> memory_write_pulse_n)
      else $error("memory write pulse longer than one cycle");
   chk_ready_needs_select:
      assert property ($fell(host_ready_n) |-> !select_n && !data_strobe_n)
      else $error("ready without select and strobe");
   chk_ready_release:
      assert property (released_s |-> host_ready_n)
      else $error("ready still low after host released");
   chk_read_drives_bus:
      assert property (!host_ready_n && !$past(host_ready_n) && rd_wr |-> data_dev_oe)
      else $error("read ready without device driving data");
   chk_no_contention:
      assert property (!(data_dev_oe && data_host_oe))
      else $error("both ends drive the data bus");
   chk_ram_enable_tied:
      assert property (internal_ram_enable_in_n == ram_enable_out_n)
      else $error("ram enable input not following output");
   chk_clear_resets:
      assert property (clear_held_s |-> !in_message && host_ready_n)
      else $error("master clear did not reset the device");
   chk_command_held:
      assert property (in_message && $past(in_message) |-> $stable(tx_rx_bit)
         && $stable(mode_code_flag))
      else $error("command bits changed within a message");
endmodule

// ==== test/terminal_status_and_host_strobes_test.sv ====
`timescale 1ns/100ps
module terminal_status_and_host_strobes_test;
   import term_pkg::*;
   logic core_clk, reset_n, par, cmd_valid, cmd_done, word_write, tag_word, event_irq;
   logic comp, req, req_read, req_mem, clear_req, busy, done, irq_seen, msb;
   logic m_seen, w_seen, t_seen, e_seen, r_seen; // sticky catchers of low pulses
   logic [4:0] straps; // strapped terminal address
   logic [15:0] cmd_word, word_data, word_addr, req_addr, req_wdata, rdata;
   role_t role;
   int n_errors, total_checks;
   term_if bus ();
   term_device i_term_device (.core_clk(core_clk), .reset_n(reset_n), .hb(bus.device),
      .terminal_address_straps(straps), .address_parity_strap(par), .cmd_valid(cmd_valid),
      .cmd_word(cmd_word), .cmd_done(cmd_done), .role(role), .word_write(word_write),
      .word_data(word_data), .word_addr(word_addr), .tag_word(tag_word),
      .event_irq(event_irq), .companion_access(comp), .transfer_counter_msb(msb));
   term_host i_term_host (.core_clk(core_clk), .reset_n(reset_n), .hb(bus.host), .req(req),
      .req_read(req_read), .req_mem(req_mem), .req_addr(req_addr), .req_wdata(req_wdata),
      .clear_req(clear_req), .busy(busy), .done(done), .rdata(rdata), .irq_seen(irq_seen));
   term_monitor i_term_monitor (.core_clk(core_clk), .reset_n(reset_n),
      .select_n(bus.select_n), .data_strobe_n(bus.data_strobe_n), .rd_wr(bus.rd_wr),
      .host_ready_n(bus.host_ready_n), .data_host_oe(bus.data_host_oe),
      .data_dev_oe(bus.data_dev_oe), .interrupt_n(bus.interrupt_n),
      .memory_write_pulse_n(bus.memory_write_pulse_n), .ram_enable_out_n(bus.ram_enable_out_n),
      .internal_ram_enable_in_n(bus.internal_ram_enable_in_n),
      .master_clear_n(bus.master_clear_n), .address_match_pulse_n(bus.address_match_pulse_n),
      .tx_rx_bit(bus.tx_rx_bit), .mode_code_flag(bus.mode_code_flag),
      .in_message(bus.in_message));
   // 20 MHz core clock
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // latch any low pulse so a later check cannot miss it
   always @(posedge core_clk)
   begin
      if (!bus.address_match_pulse_n) m_seen <= 1'b1;
      if (!bus.memory_write_pulse_n) w_seen <= 1'b1;
      if (!bus.time_tag_enable_n) t_seen <= 1'b1;
      if (!bus.companion_bus_enable_n) e_seen <= 1'b1;
      if (!bus.ram_enable_out_n) r_seen <= 1'b1;
   end
   // compare and count
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // wait n edges, then step off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #5;
   endtask
   // one host access, bounded wait for done
   task automatic host_op(input logic rd, input logic mem, input logic [15:0] a,
      input logic [15:0] d);
      int k;
      {req_read, req_mem, req_addr, req_wdata} = {rd, mem, a, d};
      req = 1'b1;
      tick(1);
      req = 1'b0;
      for (k = 0; k < 60 && done !== 1'b1; k++) tick(1);
      check("host done", 16'h1, 16'(done));
      check("host idle", 16'h0, 16'(busy));
      tick(1);
   endtask
   // close the current message
   task automatic end_msg();
      cmd_done = 1'b1;
      tick(1);
      cmd_done = 1'b0;
      tick(3);
   endtask
   // one command word pulse
   task automatic send_cmd(input logic [15:0] w);
      cmd_word = w;
      m_seen = 1'b0;
      cmd_valid = 1'b1;
      tick(1);
      cmd_valid = 1'b0;
      tick(3);
   endtask
   task automatic test_straps();
      logic [4:0] s[2] = '{5'h0a, 5'h1f};
      foreach (s[i])
         for (int p = 0; p < 2; p++)
         begin
            {straps, par} = {s[i], p[0]};
            tick(3);
            check("parity", 16'(^{s[i], p[0]}), 16'(bus.address_parity_error_n));
         end
      par = 1'b1;
      straps = 5'h0a;
      tick(3);
      $display("test_straps finished");
   endtask
   task automatic test_command();
      role = role_rt;
      send_cmd({5'h0a, 1'b1, 5'h06, 5'h03});
      check("match", 16'h1, 16'(m_seen));
      check("tr", 16'h1, 16'(bus.tx_rx_bit));
      check("field", 16'h06, 16'(bus.subaddr_mode));
      check("msb", 16'h1, 16'(msb));
      check("mode", 16'h0, 16'(bus.mode_code_flag));
      check("in msg", 16'h1, 16'(bus.in_message));
      end_msg();
      check("msg end", 16'h0, 16'(bus.in_message));
      send_cmd({5'h0a, 1'b0, 5'h1f, 5'h12});
      check("mode field", 16'h12, 16'(bus.subaddr_mode));
      check("mode flag", 16'h1, 16'(bus.mode_code_flag));
      check("mode msb", 16'h0, 16'(msb));
      end_msg();
      send_cmd({5'h0b, 1'b0, 5'h02, 5'h01});
      check("no match", 16'h0, 16'(m_seen));
      end_msg();
      $display("test_command finished");
   endtask
   task automatic test_host();
      r_seen = 1'b0;
      host_op(1'b0, 1'b1, 16'h0012, 16'ha5c3);
      check("ram enable", 16'h1, 16'(r_seen));
      host_op(1'b0, 1'b1, 16'h0013, 16'h5a3c);
      host_op(1'b1, 1'b1, 16'h0012, 16'h0000);
      check("mem read", 16'ha5c3, rdata);
      host_op(1'b0, 1'b0, 16'h0001, 16'h3c5a);
      host_op(1'b1, 1'b0, 16'h0007, 16'h0000);
      check("reg read", 16'h3c5a, rdata);
      {word_addr, word_data, w_seen} = {16'h0020, 16'h1234, 1'b0};
      word_write = 1'b1;
      tick(1);
      word_write = 1'b0;
      tick(3);
      check("mem write", 16'h1, 16'(w_seen));
      host_op(1'b1, 1'b1, 16'h0020, 16'h0000);
      check("word read", 16'h1234, rdata);
      $display("test_host finished");
   endtask
   task automatic test_events();
      event_irq = 1'b1;
      tick(1);
      event_irq = 1'b0;
      tick(6);
      check("irq", 16'h1, 16'(irq_seen));
      role = role_mon;
      {t_seen, e_seen, tag_word, comp} = 4'h3;
      tick(3);
      {tag_word, comp} = 2'h0;
      send_cmd({5'h0a, 1'b1, 5'h04, 5'h01});
      check("tag", 16'h1, 16'(t_seen));
      check("companion", 16'h1, 16'(e_seen));
      check("mon msg", 16'h0, 16'(bus.in_message));
      role = role_bc;
      send_cmd({5'h0a, 1'b1, 5'h05, 5'h01});
      clear_req = 1'b1;
      tick(3);
      clear_req = 1'b0;
      tick(6);
      check("clear", 16'h0, 16'(bus.in_message));
      check("irq clear", 16'h0, 16'(irq_seen));
      $display("test_events finished");
   endtask
   // single closing point of the run
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // cut a hang short
   initial
   begin
      repeat (4000) @(posedge core_clk);
      n_errors++;
      print_verdict();
   end
   initial
   begin
      {reset_n, par, cmd_valid, cmd_done, word_write, tag_word, event_irq} = 7'h20;
      {comp, req, req_read, req_mem, clear_req, m_seen, w_seen, t_seen, e_seen} = 9'h000;
      r_seen = 1'b0;
      {straps, cmd_word, word_data, word_addr, req_addr, req_wdata} = {5'h0a, 80'h0};
      role = role_rt;
      repeat (20) @(posedge core_clk);
      #5;
      reset_n = 1'b1;
      tick(6);
      test_straps();
      test_command();
      test_host();
      test_events();
      print_verdict();
   end
endmodule

// ==== verilog/term_device.sv ====
// Function
// - low pulse when command address matches straps
// - parity error low on even strap parity
// - hold latched transmit/receive bit per command
// - output subaddress/mode field; bit2 counter msb
// - in-message high during bc/rt transfer
// - master clear resets all logic except the pin synchronisers and the ram
// - interrupt is a pulse, not level
// - strobes ignored while select inactive
// - ready marks write taken or read data
// - memory write pulse per word written
// - internal ram enable tied to enable out
// - bus enable drives companion onto bus
// - monitor asserts tag enable for time tag
// - data bus 16 bits, bit 15 msb
// - address bus 16 bits, bit 0 lsb
// - host starts cycle with strobe and select
// - host read/write defines transfer direction
// - host memory/register select chooses target
// - mode code flag high selects mode code
`timescale 1ns/100ps
`include "term_regs.svh"
module term_device #(
   parameter int MEM_DEPTH = 256
) (
   input wire logic core_clk,
   input wire logic reset_n,
   term_if.device hb,
   input wire logic [`TA_W-1:0] terminal_address_straps,
   input wire logic address_parity_strap,
   input wire logic cmd_valid,
   input wire logic [`DATA_W-1:0] cmd_word,
   input wire logic cmd_done,
   input wire term_pkg::role_t role,
   input wire logic word_write,
   input wire logic [`DATA_W-1:0] word_data,
   input wire logic [`ADDR_W-1:0] word_addr,
   input wire logic tag_word,
   input wire logic event_irq,
   input wire logic companion_access,
   output logic transfer_counter_msb
);
   import term_pkg::*;
   // synchronised host pins
   logic sel_s1, sel_s2, stb_s1, stb_s2, rw_s1, rw_s2, mr_s1, mr_s2, mc_s1, mc_s2;
   logic rst_all_n; // combined reset, master clear included
   logic [`TA_W-1:0] ta_r; // straps caught after reset
   logic tap_r;
   logic [`DATA_W-1:0] mem [MEM_DEPTH]; // shared ram
   logic [`DATA_W-1:0] regs_r; // single internal register
   host_state_t hs_r;
   logic [3:0] lat_r; // ready latency counter
   logic [`DATA_W-1:0] rdata_r;
   logic rdoe_r, rdy_r, wr_r, irq_r, match_r, perr_r, tr_r, mcf_r, inmsg_r, ten_r, ben_r;
   logic [`SA_W-1:0] sa_r;
   logic ena_r;
   logic [`ADDR_W-1:0] a_s;
   logic is_mode; // command subaddress marks a mode code
   // pin synchronisers
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         {sel_s1, sel_s2, stb_s1, stb_s2, mc_s1, mc_s2} <= 6'h3f;
         {rw_s1, rw_s2, mr_s1, mr_s2} <= 4'h0;
      end
      else
      begin
         sel_s1 <= hb.select_n;
         sel_s2 <= sel_s1;
         stb_s1 <= hb.data_strobe_n;
         stb_s2 <= stb_s1;
         rw_s1 <= hb.rd_wr;
         rw_s2 <= rw_s1;
         mr_s1 <= hb.mem_reg;
         mr_s2 <= mr_s1;
         mc_s1 <= hb.master_clear_n;
         mc_s2 <= mc_s1;
      end
   end
   assign rst_all_n = reset_n & mc_s2;
   assign a_s = hb.addr; // stable while strobe held
   // both reserved subaddress values mean a mode code follows
   assign is_mode = (cmd_word[`CMD_SA_F] == `SA_MODE_LO) || (cmd_word[`CMD_SA_F] == `SA_MODE_HI);
   // straps sampled every cycle after release
   always_ff @(posedge core_clk or negedge rst_all_n)
   begin
      if (!rst_all_n)
      begin
         ta_r <= '0;
         tap_r <= 1'b0;
      end
      else
      begin
         ta_r <= terminal_address_straps;
         tap_r <= address_parity_strap;
      end
   end
   // command decode and status
   always_ff @(posedge core_clk or negedge rst_all_n)
   begin
      if (!rst_all_n)
      begin
         match_r <= 1'b0;
         tr_r <= 1'b0;
         sa_r <= '0;
         mcf_r <= 1'b0;
         perr_r <= 1'b0;
      end
      else
      begin
         perr_r <= ~(^{ta_r, tap_r});
         match_r <= cmd_valid && (cmd_word[`CMD_TA_F] == ta_r);
         if (cmd_valid)
         begin
            tr_r <= cmd_word[`CMD_TR_BIT];
            sa_r <= is_mode ? cmd_word[`CMD_CNT_F] : cmd_word[`CMD_SA_F];
            mcf_r <= is_mode;
         end
      end
   end
   // message, tag, enables, events
   always_ff @(posedge core_clk or negedge rst_all_n)
   begin
      if (!rst_all_n)
      begin
         inmsg_r <= 1'b0;
         ten_r <= 1'b0;
         ben_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else
      begin
         if (cmd_valid && (role == role_bc || role == role_rt))
            inmsg_r <= 1'b1;
         else if (cmd_done)
            inmsg_r <= 1'b0;
         ten_r <= (role == role_mon) && tag_word;
         ben_r <= companion_access;
         irq_r <= event_irq & ~irq_r; // one cycle pulse
      end
   end
   // host sequencer
   always_ff @(posedge core_clk or negedge rst_all_n)
   begin
      if (!rst_all_n)
      begin
         hs_r <= h_idle;
         lat_r <= 4'h0;
         rdy_r <= 1'b0;
         rdoe_r <= 1'b0;
         rdata_r <= `ZERO16;
         regs_r <= `ZERO16;
         wr_r <= 1'b0;
         ena_r <= 1'b0;
      end
      else
      begin
         wr_r <= 1'b0;
         case (hs_r)
            h_idle:
            begin
               if (!sel_s2 && !stb_s2)
               begin
                  hs_r <= h_wait;
                  lat_r <= `READY_LAT;
                  ena_r <= mr_s2 & ~rw_s2;
               end
               else if (word_write)
               begin
                  mem[word_addr[$clog2(MEM_DEPTH)-1:0]] <= word_data;
                  wr_r <= 1'b1;
               end
            end
            h_wait:
            begin
               if (lat_r > `PULSE_CYC)
                  lat_r <= lat_r - 4'h1;
               else
               begin
                  hs_r <= h_ready;
                  rdy_r <= 1'b1;
                  if (rw_s2) // read
                  begin
                     rdoe_r <= 1'b1;
                     rdata_r <= mr_s2 ? mem[a_s[$clog2(MEM_DEPTH)-1:0]] : regs_r;
                  end
                  else if (mr_s2 && !hb.internal_ram_enable_in_n)
                  begin
                     mem[a_s[$clog2(MEM_DEPTH)-1:0]] <= hb.data_from_host;
                     wr_r <= 1'b1;
                  end
                  else if (!mr_s2)
                     regs_r <= hb.data_from_host;
               end
            end
            h_ready:
            begin
               if (stb_s2 || sel_s2)
               begin
                  hs_r <= h_idle;
                  rdy_r <= 1'b0;
                  rdoe_r <= 1'b0;
                  ena_r <= 1'b0;
               end
            end
            default: hs_r <= h_idle;
         endcase
      end
   end
   assign hb.address_match_pulse_n = ~match_r;
   assign hb.address_parity_error_n = ~perr_r;
   assign hb.tx_rx_bit = tr_r;
   assign hb.subaddr_mode = sa_r;
   assign transfer_counter_msb = sa_r[`SA_CNT_BIT];
   assign hb.mode_code_flag = mcf_r;
   assign hb.in_message = inmsg_r;
   assign hb.interrupt_n = ~irq_r;
   assign hb.host_ready_n = ~rdy_r;
   assign hb.data_from_dev = rdata_r;
   assign hb.data_dev_oe = rdoe_r;
   assign hb.memory_write_pulse_n = ~wr_r;
   assign hb.ram_enable_out_n = ~ena_r;
   assign hb.companion_bus_enable_n = ~ben_r;
   assign hb.time_tag_enable_n = ~ten_r;
endmodule

// ==== verilog/term_host.sv ====
`timescale 1ns/100ps
`include "term_regs.svh"
module term_host (
   input wire logic core_clk,
   input wire logic reset_n,
   term_if.host hb,
   input wire logic req,
   input wire logic req_read,
   input wire logic req_mem,
   input wire logic [`ADDR_W-1:0] req_addr,
   input wire logic [`DATA_W-1:0] req_wdata,
   input wire logic clear_req,
   output logic busy,
   output logic done,
   output logic [`DATA_W-1:0] rdata,
   output logic irq_seen
);
   import term_pkg::*;
   logic rdy_s1, rdy_s2, int_s1, int_s2, int_d;
   host_state_t st_r;
   logic sel_r, stb_r, rw_r, mr_r, oe_r, done_r, mc_r, irq_r;
   logic [`ADDR_W-1:0] a_r;
   logic [`DATA_W-1:0] wd_r, rd_r;
   // device ready and interrupt outputs synchronised
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         {rdy_s1, rdy_s2, int_s1, int_s2, int_d} <= 5'h1f;
      end
      else
      begin
         rdy_s1 <= hb.host_ready_n;
         rdy_s2 <= rdy_s1;
         int_s1 <= hb.interrupt_n;
         int_s2 <= int_s1;
         int_d <= int_s2;
      end
   end
   // interrupt pulse catch, set wins over clear
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         irq_r <= 1'b0;
      else if (int_d && !int_s2)
         irq_r <= 1'b1;
      else if (clear_req)
         irq_r <= 1'b0;
   end
   // master clear low in reset and while a clear is requested
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         mc_r <= 1'b0;
      else
         mc_r <= ~clear_req;
   end
   // access sequencer
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_r <= h_idle;
         {sel_r, stb_r} <= 2'h0;
         {rw_r, mr_r, oe_r, done_r} <= 4'h0;
         a_r <= `ZERO16;
         wd_r <= `ZERO16;
         rd_r <= `ZERO16;
      end
      else
      begin
         done_r <= 1'b0;
         case (st_r)
            h_idle:
            begin
               if (req)
               begin
                  sel_r <= 1'b1;
                  stb_r <= 1'b1;
                  rw_r <= req_read;
                  mr_r <= req_mem;
                  a_r <= req_addr;
                  wd_r <= req_wdata;
                  oe_r <= ~req_read;
                  st_r <= h_wait;
               end
            end
            h_wait:
            begin
               if (!rdy_s2)
               begin
                  rd_r <= hb.data_from_dev;
                  sel_r <= 1'b0;
                  stb_r <= 1'b0;
                  st_r <= h_done;
               end
            end
            h_done:
            begin
               if (rdy_s2)
               begin
                  oe_r <= 1'b0;
                  done_r <= 1'b1;
                  st_r <= h_idle;
               end
            end
            default: st_r <= h_idle;
         endcase
      end
   end
   assign hb.select_n = ~sel_r;
   assign hb.data_strobe_n = ~stb_r;
   assign hb.rd_wr = rw_r;
   assign hb.mem_reg = mr_r;
   assign hb.addr = a_r;
   assign hb.data_from_host = wd_r;
   assign hb.data_host_oe = oe_r;
   assign hb.internal_ram_enable_in_n = hb.ram_enable_out_n;
   assign hb.master_clear_n = mc_r;
   assign busy = (st_r != h_idle);
   assign done = done_r;
   assign rdata = rd_r;
   assign irq_seen = irq_r;
endmodule

// ==== verilog/term_if.sv ====
`timescale 1ns/100ps
interface term_if;
   // host strobes and enables
   logic select_n;
   logic data_strobe_n;
   logic rd_wr;
   logic mem_reg;
   logic host_ready_n;
   logic [15:0] addr;
   logic [15:0] data_from_host;
   logic data_host_oe;
   logic [15:0] data_from_dev;
   logic data_dev_oe;
   logic interrupt_n;
   logic memory_write_pulse_n;
   logic ram_enable_out_n;
   logic internal_ram_enable_in_n;
   logic companion_bus_enable_n;
   logic time_tag_enable_n;
   logic master_clear_n;
   // terminal status
   logic address_match_pulse_n;
   logic address_parity_error_n;
   logic tx_rx_bit;
   logic [4:0] subaddr_mode;
   logic mode_code_flag;
   logic in_message;
   modport device (
      input select_n, data_strobe_n, rd_wr, mem_reg, addr, data_from_host, data_host_oe,
      input internal_ram_enable_in_n, master_clear_n,
      output host_ready_n, data_from_dev, data_dev_oe, interrupt_n, memory_write_pulse_n,
      output ram_enable_out_n, companion_bus_enable_n, time_tag_enable_n,
      output address_match_pulse_n, address_parity_error_n, tx_rx_bit, subaddr_mode,
      output mode_code_flag, in_message
   );
   modport host (
      output select_n, data_strobe_n, rd_wr, mem_reg, addr, data_from_host, data_host_oe,
      output internal_ram_enable_in_n, master_clear_n,
      input host_ready_n, data_from_dev, data_dev_oe, interrupt_n, memory_write_pulse_n,
      input ram_enable_out_n, companion_bus_enable_n, time_tag_enable_n,
      input address_match_pulse_n, address_parity_error_n, tx_rx_bit, subaddr_mode,
      input mode_code_flag, in_message
   );
endinterface

// ==== verilog/term_pkg.sv ====
package term_pkg;
   // operating role of the terminal
   typedef enum logic [1:0] {role_idle_t_v, role_bc, role_rt, role_mon} role_t;
   // host access sequencer states
   typedef enum logic [1:0] {h_idle, h_wait, h_ready, h_done} host_state_t;
endpackage

// ==== verilog/term_regs.svh ====
`ifndef TERM_REGS_SVH
`define TERM_REGS_SVH
// bus widths
`define DATA_W 16
`define ADDR_W 16
`define TA_W 5
`define SA_W 5
// command word fields
`define CMD_TA_F 15:11
`define CMD_TR_BIT 10
`define CMD_SA_F 9:5
`define CMD_CNT_F 4:0
// subaddress values that mark a mode code
`define SA_MODE_LO 5'h00
`define SA_MODE_HI 5'h1f
// position of the subaddress/mode bit that doubles as counter msb
`define SA_CNT_BIT 2
// least pulse length in clock cycles
`define PULSE_CYC 4'h1
// host access latency in clock cycles before ready
`define READY_LAT 4'h2
// reset values
`define ZERO16 16'h0000
`endif
